/* File: hdl/lps_sequencer.sv */
/*
 Laser pulse sequencer: pulse and sync generation in five modes, burst
 envelope, trigger one-shots, settings store/load, interlock and fault trip.
 Assumes clock is the 10 ns time base, config ports and the command pulses
 come from logic on this clock, and the back-panel pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Width and period are counts of 10 ns steps.
// - Width above period gives continuous output.
// - A sync pulse of its own programmed width accompanies each pulse; with continuous external control the sync follows the trigger level instead.
// - Pulsing mode repeats pulses with no external input.
// - External control with continuous settings: output follows trigger level.
// - External control with pulsed settings: trigger gates the pulse train.
// - Burst mode alternates burst-on pulses with burst-off silence.
// - Trigger burst mode: each trigger starts one burst, then waits.
// - External trigger mode: one pulse per trigger, programmed width.
// - Store command copies current settings into the store.
// - At power-up the stored settings become the active ones.
// - Apply command starts the selected mode with current settings.
// - Peak current above the limit shuts the output down.
// - Burst trigger starts a burst on its rising edge only.
// - A triggered burst ends after the programmed pulse count.
// - Triggered pulse width comes from settings, not trigger high time.
// - Sync output is aligned with each output pulse.
// - Gate input enables or blocks the internal pulse train.
// - Output stays disabled unless the interlock is closed.
// - Output-enabled status is high exactly while output is enabled.
// - In burst mode that status follows the burst envelope.
module lps_sequencer
   import lps_pkg::*;
#(
   parameter int CW = CNT_W,
   parameter int BW = BURST_W
) (
   input  wire logic          clock,
   input  wire logic          rst_n,
   input  wire logic          clkEn,
   input  wire logic [CW-1:0] cfgWidth,
   input  wire logic [CW-1:0] cfgPeriod,
   input  wire logic [CW-1:0] cfgSyncWidth,
   input  wire logic [CW-1:0] cfgBurstCount,
   input  wire logic [BW-1:0] cfgBurstOn,
   input  wire logic [BW-1:0] cfgBurstOff,
   input  wire logic [2:0]    cfgMode,
   input  wire logic          cfgGateEn,
   input  wire logic          storeCmd,
   input  wire logic          applyCmd,
   input  wire logic          extTrigPin,
   input  wire logic          burstTrigPin,
   input  wire logic          gatePin,
   input  wire logic          interlockPin,
   input  wire logic          overCurrentPin,
   output logic               driveOut,
   output logic               syncOut,
   output logic               laserOn,
   output logic               faultFlag,
   output logic               running
);
   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   if (CW < 2 || BW < CW) begin : g_badWidth
      $error("lps_sequencer: need CW >= 2 and BW >= CW");
   end
   if (STEP_CYC != 1) begin : g_badStep
      $error("lps_sequencer: time base must give one cycle per step");
   end

   // ---------------------------------------------------------------
   // Settings word layout
   // ---------------------------------------------------------------
   localparam int F_WID  = 0;
   localparam int F_PER  = CW;
   localparam int F_SYN  = 2 * CW;
   localparam int F_BCNT = 3 * CW;
   localparam int F_BON  = 4 * CW;
   localparam int F_BOFF = 4 * CW + BW;
   localparam int F_MODE = 4 * CW + 2 * BW;
   localparam int F_GATE = F_MODE + MODE_W;
   localparam int DW     = F_GATE + 1;
   localparam logic [DW-1:0] DEF_CFG = {1'b0, MODE_PULSE,
      BW'(DEF_BOFF), BW'(DEF_BON), CW'(DEF_BCOUNT),
      CW'(DEF_SYNC), CW'(DEF_PERIOD), CW'(DEF_WIDTH)};

   // True once count c is on its last step of a span of lim (0 acts as 1)
   function automatic logic lastStep(input logic [BW-1:0] c,
                                     input logic [BW-1:0] lim);
      lastStep = ({1'b0, c} + (BW + 1)'(1)) >= {1'b0, lim};
   endfunction : lastStep

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rstMeta_ff;
   logic rstSync_ff;
   wire  rstN = rstSync_ff;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_ff <= 1'b0;
         rstSync_ff <= 1'b0;
      end else if (clkEn) begin
         rstMeta_ff <= 1'b1;
         rstSync_ff <= rstMeta_ff;
      end
   end

   // ---------------------------------------------------------------
   // Pins and settings store
   // ---------------------------------------------------------------
   lps_pin_if #(.N(PIN_N)) pin ();
   wire [PIN_N-1:0] pinRaw = {overCurrentPin, interlockPin, gatePin, burstTrigPin, extTrigPin};

   lps_pin_sync #(.N(PIN_N)) u_sync (
      .clock (clock),
      .rstN  (rstN),
      .clkEn (clkEn),
      .pinIn (pinRaw),
      .pins  (pin.src)
   );

   wire [DW-1:0] cfgWord = {cfgGateEn, cfgMode, cfgBurstOff, cfgBurstOn,
      cfgBurstCount, cfgSyncWidth, cfgPeriod, cfgWidth};
   logic [DW-1:0] storedCfg;

   lps_cfg_store #(.DW(DW), .INIT(DEF_CFG)) u_store (
      .clock  (clock),
      .clkEn  (clkEn),
      .wrEn   (storeCmd),
      .wrData (cfgWord),
      .rdData (storedCfg)
   );

   // ---------------------------------------------------------------
   // Active settings
   // ---------------------------------------------------------------
   logic            rdValid_ff;
   logic            loadPend_ff;
   logic [DW-1:0]   act_ff;
   wire             applyOk = applyCmd & ~loadPend_ff;
   wire             loadNow = loadPend_ff & rdValid_ff;
   wire [DW-1:0]    nxt_act = loadNow ? storedCfg : applyOk ? cfgWord : act_ff;

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         rdValid_ff  <= 1'b0;
         loadPend_ff <= 1'b1;
         act_ff      <= DEF_CFG;
      end else if (clkEn) begin
         rdValid_ff  <= 1'b1;
         loadPend_ff <= loadPend_ff & ~rdValid_ff;
         act_ff      <= nxt_act;
      end
   end

   wire [CW-1:0] actWidth  = act_ff[F_WID +: CW];
   wire [CW-1:0] actPeriod = act_ff[F_PER +: CW];
   wire [CW-1:0] actSync   = act_ff[F_SYN +: CW];
   wire [CW-1:0] actBCount = act_ff[F_BCNT +: CW];
   wire [BW-1:0] actBOn    = act_ff[F_BON +: BW];
   wire [BW-1:0] actBOff   = act_ff[F_BOFF +: BW];
   wire          actGateEn = act_ff[F_GATE];
   lps_mode_t    actMode;
   assign actMode = lps_mode_t'(act_ff[F_MODE +: MODE_W]);

   // ---------------------------------------------------------------
   // Mode decode
   // ---------------------------------------------------------------
   wire isPulse     = actMode == MODE_PULSE;
   wire isExtCtrl   = actMode == MODE_EXTCTRL;
   wire isBurst     = actMode == MODE_BURST;
   wire isTrigBurst = actMode == MODE_TRIGBURST;
   wire isExtTrig   = ~(isPulse | isExtCtrl | isBurst | isTrigBurst); // Spare codes run as trigger mode
   wire trigLvl     = pin.level[PIN_TRIG];
   wire trigRise    = pin.rise[PIN_TRIG];
   wire burstRise   = pin.rise[PIN_BTRIG];
   wire gateLvl     = pin.level[PIN_GATE];
   wire ilkClosed   = pin.level[PIN_ILK];
   wire overCur     = pin.level[PIN_OVC];

   // ---------------------------------------------------------------
   // Pulse engine
   // ---------------------------------------------------------------
   logic          running_ff;
   logic          fault_ff;
   logic [CW-1:0] cnt_ff;
   logic          shot_ff;
   logic          inBurst_ff;
   logic          burstPhase_ff;
   logic [BW-1:0] burstCnt_ff;

   wire contMode = actWidth > actPeriod;
   wire shapeMode = isExtCtrl & contMode;
   wire outEn = running_ff & ilkClosed & ~fault_ff;
   wire engEn = running_ff & (isPulse ? (~actGateEn | gateLvl) :
                              isExtCtrl ? trigLvl :
                              isBurst ? burstPhase_ff :
                              isTrigBurst ? inBurst_ff : shot_ff);
   wire wrap = lastStep(BW'(cnt_ff), BW'(actPeriod));
   wire [CW-1:0] nxt_cnt = (~engEn | wrap) ? '0 : cnt_ff + CW'(1);
   wire pulseLvl = engEn & (contMode | (cnt_ff < actWidth));
   wire syncLvl = engEn & (cnt_ff < actSync);

   // One-shot covers both the pulse and its sync, then rearms
   wire shotEnd = wrap | (lastStep(BW'(cnt_ff), BW'(actWidth)) & lastStep(BW'(cnt_ff), BW'(actSync)));
   wire nxt_shot = ~(running_ff & isExtTrig) ? 1'b0 : shot_ff ? ~shotEnd : trigRise;

   wire nxt_drive = outEn & (shapeMode ? trigLvl : pulseLvl);
   wire nxt_sync = outEn & (shapeMode ? trigLvl : syncLvl);
   wire nxt_laserOn = isBurst ? outEn & burstPhase_ff : outEn;
   // Set wins over the apply that clears it
   wire nxt_fault = (running_ff & overCur) | (fault_ff & ~applyOk);

   // ---------------------------------------------------------------
   // Burst sequencing
   // ---------------------------------------------------------------
   logic          nxt_inBurst;
   logic          nxt_burstPhase;
   logic [BW-1:0] nxt_burstCnt;
   wire burstLim = lastStep(burstCnt_ff, burstPhase_ff ? actBOn : actBOff);
   wire trigEnd = engEn & wrap & lastStep(burstCnt_ff, BW'(actBCount));

   always_comb begin
      nxt_inBurst    = inBurst_ff;
      nxt_burstPhase = burstPhase_ff;
      nxt_burstCnt   = burstCnt_ff;
      if (!running_ff) begin
         nxt_inBurst    = 1'b0;
         nxt_burstPhase = 1'b1;
         nxt_burstCnt   = '0;
      end else if (isBurst) begin
         // Envelope timer alternates on and off spans
         nxt_burstCnt   = burstLim ? '0 : burstCnt_ff + BW'(1);
         nxt_burstPhase = burstPhase_ff ^ burstLim;
      end else if (isTrigBurst) begin
         if (!inBurst_ff) begin
            // Edge only: a held-high trigger starts one burst
            nxt_inBurst  = trigRise | burstRise;
            nxt_burstCnt = '0;
         end else if (trigEnd) begin
            nxt_inBurst  = 1'b0;
            nxt_burstCnt = '0;
         end else if (engEn & wrap) begin
            nxt_burstCnt = burstCnt_ff + BW'(1);
         end
      end
   end

   // ---------------------------------------------------------------
   // State and outputs
   // ---------------------------------------------------------------
   logic driveOut_ff;
   logic syncOut_ff;
   logic laserOn_ff;

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         running_ff <= 1'b0;
         fault_ff   <= 1'b0;
      end else if (clkEn) begin
         running_ff <= running_ff | applyOk;
         fault_ff   <= nxt_fault;
      end
   end

   // Apply restarts every timer so a new mode starts clean
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         cnt_ff        <= '0;
         shot_ff       <= 1'b0;
         inBurst_ff    <= 1'b0;
         burstPhase_ff <= 1'b1;
         burstCnt_ff   <= '0;
      end else if (clkEn) begin
         cnt_ff        <= applyOk ? '0 : nxt_cnt;
         shot_ff       <= ~applyOk & nxt_shot;
         inBurst_ff    <= ~applyOk & nxt_inBurst;
         burstPhase_ff <= applyOk | nxt_burstPhase;
         burstCnt_ff   <= applyOk ? '0 : nxt_burstCnt;
      end
   end

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         driveOut_ff <= 1'b0;
         syncOut_ff  <= 1'b0;
         laserOn_ff  <= 1'b0;
      end else if (clkEn) begin
         driveOut_ff <= nxt_drive;
         syncOut_ff  <= nxt_sync;
         laserOn_ff  <= nxt_laserOn;
      end
   end

   assign driveOut  = driveOut_ff;
   assign syncOut   = syncOut_ff;
   assign laserOn   = laserOn_ff;
   assign faultFlag = fault_ff;
   assign running   = running_ff;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_contOn;
      @(posedge clock) disable iff (!rstN || !clkEn)
      outEn && isPulse && !actGateEn && contMode |=> driveOut_ff;
   endproperty
   a_contOn: assert property (p_contOn) else $error("continuous output missing");
   property p_ilkOff;
      @(posedge clock) disable iff (!rstN || !clkEn)
      !ilkClosed |=> !driveOut_ff && !syncOut_ff;
   endproperty
   a_ilkOff: assert property (p_ilkOff) else $error("output with open interlock");
   property p_trip;
      @(posedge clock) disable iff (!rstN || !clkEn)
      running_ff && overCur |=> faultFlag ##1 !driveOut_ff;
   endproperty
   a_trip: assert property (p_trip) else $error("overcurrent did not shut output");
   property p_faultHold;
      @(posedge clock) disable iff (!rstN || !clkEn)
      fault_ff && !applyCmd |=> fault_ff && !driveOut_ff;
   endproperty
   a_faultHold: assert property (p_faultHold) else $error("fault released without apply");
   property p_shape;
      @(posedge clock) disable iff (!rstN || !clkEn)
      outEn && shapeMode |=> driveOut_ff == $past(trigLvl);
   endproperty
   a_shape: assert property (p_shape) else $error("output not following trigger");
   property p_gateLow;
      @(posedge clock) disable iff (!rstN || !clkEn)
      running_ff && isExtCtrl && !contMode && !trigLvl |=> !driveOut_ff;
   endproperty
   a_gateLow: assert property (p_gateLow) else $error("pulse while gate low");
   property p_burstIdle;
      @(posedge clock) disable iff (!rstN || !clkEn)
      running_ff && isBurst && !burstPhase_ff |=> !driveOut_ff && !laserOn_ff;
   endproperty
   a_burstIdle: assert property (p_burstIdle) else $error("activity in burst-off");
   property p_trigShot;
      @(posedge clock) disable iff (!rstN || !clkEn)
      outEn && isExtTrig && trigRise && !shot_ff && actWidth != '0 && !applyCmd |=> shot_ff ##1 driveOut_ff;
   endproperty
   a_trigShot: assert property (p_trigShot) else $error("trigger gave no pulse");
   property p_syncAlign;
      @(posedge clock) disable iff (!rstN || !clkEn)
      outEn && engEn && cnt_ff == '0 && actSync != '0 && actWidth != '0 |=> syncOut_ff && driveOut_ff;
   endproperty
   a_syncAlign: assert property (p_syncAlign) else $error("sync not aligned");
   property p_status;
      @(posedge clock) disable iff (!rstN || !clkEn)
      !isBurst |=> laserOn_ff == $past(outEn);
   endproperty
   a_status: assert property (p_status) else $error("status differs from enable");
   property p_apply;
      @(posedge clock) disable iff (!rstN || !clkEn)
      applyOk |=> running_ff && act_ff == $past(cfgWord);
   endproperty
   a_apply: assert property (p_apply) else $error("apply did not take settings");
endmodule : lps_sequencer
`default_nettype wire

/* File: hdl/lps_pkg.sv */
/*
 Shared constants for the laser pulse sequencer: time base, field widths,
 pin indices, default stored settings and the output modes.
 Assumes nothing of its surroundings.
*/
package lps_pkg;
   // ---------------------------------------------------------------
   // Time base
   // ---------------------------------------------------------------
   localparam int STEP_NS          = 10;
   localparam int TIMEBASE_MHZ     = 100;
   localparam int STEP_CYC         = STEP_NS * TIMEBASE_MHZ / 1000;
   localparam int EXT_CTRL_MAX_KHZ = 80;
   // ---------------------------------------------------------------
   // Widths and pins
   // ---------------------------------------------------------------
   localparam int CNT_W     = 16;
   localparam int BURST_W   = 24;
   localparam int MODE_W    = 3;
   localparam int PIN_TRIG  = 0;
   localparam int PIN_BTRIG = 1;
   localparam int PIN_GATE  = 2;
   localparam int PIN_ILK   = 3;
   localparam int PIN_OVC   = 4;
   localparam int PIN_N     = 5;
   // ---------------------------------------------------------------
   // Factory settings, in 10 ns steps
   // ---------------------------------------------------------------
   localparam logic [CNT_W-1:0]   DEF_WIDTH  = 16'h0064;
   localparam logic [CNT_W-1:0]   DEF_PERIOD = 16'h03e8;
   localparam logic [CNT_W-1:0]   DEF_SYNC   = 16'h0032;
   localparam logic [CNT_W-1:0]   DEF_BCOUNT = 16'h000a;
   localparam logic [BURST_W-1:0] DEF_BON    = 24'h002710;
   localparam logic [BURST_W-1:0] DEF_BOFF   = 24'h002710;
   typedef enum logic [MODE_W-1:0] {
      MODE_PULSE,
      MODE_EXTCTRL,
      MODE_BURST,
      MODE_TRIGBURST,
      MODE_EXTTRIG
   } lps_mode_t;
endpackage : lps_pkg

/* File: hdl/lps_pin_if.sv */
/*
 Synchronised back-panel pin levels and rising-edge pulses.
 Assumes one clock domain on both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface lps_pin_if #(parameter int N = 5);
   logic [N-1:0] level;
   logic [N-1:0] rise;
   modport src (output level, rise);
   modport dst (input level, rise);
endinterface : lps_pin_if
`default_nettype wire

/* File: hdl/lps_pin_sync.sv */
/*
 Three-stage synchroniser for asynchronous back-panel pins; a change is
 taken once stages two and three agree.
 Assumes a synchronised active-low reset and the block clock enable.
*/
`timescale 1ns/1ps
`default_nettype none
module lps_pin_sync
   import lps_pkg::*;
#(
   parameter int N = PIN_N
) (
   input  wire logic         clock,
   input  wire logic         rstN,
   input  wire logic         clkEn,
   input  wire logic [N-1:0] pinIn,
   lps_pin_if.src            pins
);
   logic [N-1:0] meta_ff;
   logic [N-1:0] s2_ff;
   logic [N-1:0] s3_ff;
   logic [N-1:0] level_ff;
   logic [N-1:0] rise_ff;
   wire  [N-1:0] agree     = ~(s2_ff ^ s3_ff);
   wire  [N-1:0] nxt_level = (agree & s2_ff) | (~agree & level_ff);
   wire  [N-1:0] nxt_rise  = nxt_level & ~level_ff;

   // Glitch shorter than one cycle never reaches the level
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         meta_ff  <= '0;
         s2_ff    <= '0;
         s3_ff    <= '0;
         level_ff <= '0;
         rise_ff  <= '0;
      end else if (clkEn) begin
         meta_ff  <= pinIn;
         s2_ff    <= meta_ff;
         s3_ff    <= s2_ff;
         level_ff <= nxt_level;
         rise_ff  <= nxt_rise;
      end
   end

   assign pins.level = level_ff;
   assign pins.rise  = rise_ff;
endmodule : lps_pin_sync
`default_nettype wire

/* File: hdl/lps_cfg_store.sv */
/*
 Settings store: one wide word that keeps its content across reset, read
 back through a register.
 Assumes content is only written by the store command.
*/
`timescale 1ns/1ps
`default_nettype none
module lps_cfg_store #(
   parameter int            DW   = 8,
   parameter logic [DW-1:0] INIT = '0
) (
   input  wire logic          clock,
   input  wire logic          clkEn,
   input  wire logic          wrEn,
   input  wire logic [DW-1:0] wrData,
   output logic      [DW-1:0] rdData
);
   // No reset on purpose: content stands in for non-volatile memory
   logic [DW-1:0] mem_ff = INIT;
   logic [DW-1:0] rdData_ff;

   always_ff @(posedge clock) begin
      if (clkEn) begin
         if (wrEn) begin
            mem_ff <= wrData;
         end
         rdData_ff <= mem_ff;
      end
   end

   assign rdData = rdData_ff;
endmodule : lps_cfg_store
`default_nettype wire

/* File: sim/lps_trig_src.sv */
/*
 Far-side trigger source driving the trigger and burst trigger pins.
 Assumes the bench clock; both pins idle low between pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module lps_trig_src
   import lps_pkg::*;
(
   input  wire logic clock,
   output logic      trigPin,
   output logic      burstPin
);
   // -----------------------------------------------------------
   // Rate limit in time-base cycles
   // -----------------------------------------------------------
   localparam int MIN_CYC = TIMEBASE_MHZ * 1000 / EXT_CTRL_MAX_KHZ;
   initial begin
      trigPin  = 1'b0;
      burstPin = 1'b0;
   end
   // One pulse, then a gap long enough to respect the rate limit
   task automatic fire(input bit useBurst, input int hi, input int lo);
      int gap;
      gap = (hi + lo < MIN_CYC) ? MIN_CYC - hi : lo;
      @(negedge clock);
      if (useBurst) begin
         burstPin = 1'b1;
      end else begin
         trigPin = 1'b1;
      end
      repeat (hi) @(negedge clock);
      trigPin  = 1'b0;
      burstPin = 1'b0;
      repeat (gap) @(negedge clock);
   endtask : fire
endmodule : lps_trig_src
`default_nettype wire

/* File: sim/laser_pulse_sequencer_tb.sv */
/*
 Self-checking bench for the pulse sequencer: random settings, all modes.
 Assumes the design package and a trigger source model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module laser_pulse_sequencer_tb;
   import lps_pkg::*;
   logic clock = 1'b0, rst_n = 1'b0, storeCmd = 1'b0, applyCmd = 1'b0;
   logic gatePin = 1'b0, interlockPin = 1'b1, overCurrentPin = 1'b0, cfgGateEn = 1'b0, clkEn = 1'b1;
   logic [CNT_W-1:0]   cfgWidth = '0, cfgPeriod = '0, cfgSyncWidth = '0, cfgBurstCount = '0;
   logic [BURST_W-1:0] cfgBurstOn = '0, cfgBurstOff = '0;
   logic [2:0]         cfgMode = '0;
   logic driveOut, syncOut, laserOn, faultFlag, running, trigPin, burstPin;
   int bad_count = 0, checks_done = 0, hiDrv, hiSync, hiOn, rises, w, p, s, n, on;
   bit lastDrv;
   always #12.5 clock = ~clock;
   lps_trig_src SRC (.clock(clock), .trigPin(trigPin), .burstPin(burstPin));
   lps_sequencer DUT (.clock(clock), .rst_n(rst_n), .clkEn(clkEn), .cfgWidth(cfgWidth),
      .cfgPeriod(cfgPeriod), .cfgSyncWidth(cfgSyncWidth), .cfgBurstCount(cfgBurstCount),
      .cfgBurstOn(cfgBurstOn), .cfgBurstOff(cfgBurstOff), .cfgMode(cfgMode), .cfgGateEn(cfgGateEn),
      .storeCmd(storeCmd), .applyCmd(applyCmd), .extTrigPin(trigPin), .burstTrigPin(burstPin),
      .gatePin(gatePin), .interlockPin(interlockPin), .overCurrentPin(overCurrentPin),
      .driveOut(driveOut), .syncOut(syncOut), .laserOn(laserOn), .faultFlag(faultFlag),
      .running(running));
   // -----------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------
   function automatic int hiExp(input int a, input int b, input int k);
      return (a < b ? a : b) * k;
   endfunction : hiExp
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic summarize();
      $display("Checks done %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize
   // Window counts; phase-free when k is whole periods
   task automatic measure(input int k);
      hiDrv = 0;
      hiSync = 0;
      hiOn = 0;
      rises = 0;
      lastDrv = (driveOut === 1'b1);
      repeat (k) begin
         @(negedge clock);
         hiDrv += int'(driveOut === 1'b1);
         hiSync += int'(syncOut === 1'b1);
         hiOn += int'(laserOn === 1'b1);
         rises += int'(driveOut === 1'b1 && !lastDrv);
         lastDrv = (driveOut === 1'b1);
      end
   endtask : measure
   task automatic apply(input logic [2:0] m, input int aw, input int ap, input int as);
      @(negedge clock);
      cfgMode = m;
      cfgWidth = CNT_W'(aw);
      cfgPeriod = CNT_W'(ap);
      cfgSyncWidth = CNT_W'(as);
      applyCmd = 1'b1;
      @(negedge clock);
      applyCmd = 1'b0;
      repeat (4) @(negedge clock);
   endtask : apply
   task automatic pick();
      w = 1 + $urandom % 40;
      p = w + 1 + $urandom % 30;
      s = 1 + $urandom % 60;
   endtask : pick
   // -----------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------
   initial begin
      repeat (90000) @(posedge clock);
      bad_count++;
      summarize();
   end
   initial begin
      void'($urandom(67864));
      repeat (8) @(negedge clock);
      rst_n = 1'b1;
      repeat (6) @(negedge clock);
      check({31'h0, running}, 32'h0);
      storeCmd = 1'b1;
      @(negedge clock);
      storeCmd = 1'b0;
      repeat (3) begin
         pick();
         apply(MODE_PULSE, w, p, s);
         measure(3 * p);
         check(hiDrv, hiExp(w, p, 3));
         check(hiSync, hiExp(s, p, 3));
         check(rises, 3);
         check(hiOn, 3 * p);
      end
      n = int'(driveOut === 1'b1);
      clkEn = 1'b0;
      measure(20);
      check(hiDrv, 20 * n);
      check(hiOn, 20);
      clkEn = 1'b1;
      measure(3 * p);
      check(hiDrv, hiExp(w, p, 3));
      $display("Test pulsing done");
      apply(MODE_PULSE, p + 5, p, s);
      measure(100);
      check(hiDrv, 100);
      pick();
      cfgGateEn = 1'b1;
      apply(MODE_PULSE, w, p, s);
      measure(3 * p);
      check(hiDrv, 0);
      gatePin = 1'b1;
      repeat (8) @(negedge clock);
      measure(3 * p);
      check(hiDrv, hiExp(w, p, 3));
      cfgGateEn = 1'b0;
      interlockPin = 1'b0;
      repeat (8) @(negedge clock);
      measure(3 * p);
      check(hiDrv + hiOn, 0);
      interlockPin = 1'b1;
      overCurrentPin = 1'b1;
      repeat (6) @(negedge clock);
      overCurrentPin = 1'b0;
      repeat (8) @(negedge clock);
      measure(3 * p);
      check(hiDrv, 0);
      check({31'h0, faultFlag}, 32'h1);
      apply(MODE_PULSE, w, p, s);
      measure(3 * p);
      check(hiDrv, hiExp(w, p, 3));
      check({31'h0, faultFlag}, 32'h0);
      $display("Test protection done");
      on = 3 * p + $urandom % 50;
      cfgBurstOn = BURST_W'(on);
      cfgBurstOff = BURST_W'(5 + $urandom % 80);
      apply(MODE_BURST, w, p, s);
      measure(2 * (on + int'(cfgBurstOff)));
      check(hiOn, 2 * on);
      check(hiDrv > 0 && hiDrv < 2 * on, 1);
      apply(MODE_EXTTRIG, w, p, s);
      fork
         repeat (3) SRC.fire(1'b0, 2 + $urandom % 50, 0);
         measure(3800);
      join
      check(hiDrv, 3 * w);
      check(rises, 3);
      n = 2 + $urandom % 5;
      cfgBurstCount = CNT_W'(n);
      apply(MODE_TRIGBURST, w, p, s);
      fork
         SRC.fire(1'b1, 600, 0);
         measure(1400);
      join
      check(hiDrv, n * w);
      check(rises, n);
      $display("Test triggered modes done");
      apply(MODE_EXTCTRL, w, p, s);
      measure(3 * p);
      check(hiDrv, 0);
      fork
         SRC.fire(1'b0, 3 * p, 0);
         measure(1300);
      join
      check(hiDrv, hiExp(w, p, 3));
      n = 10 + $urandom % 200;
      apply(MODE_EXTCTRL, p + 3, p, s);
      fork
         SRC.fire(1'b0, n, 0);
         measure(1300);
      join
      check(hiDrv, n);
      $display("Test external control done");
      summarize();
   end
endmodule : laser_pulse_sequencer_tb
`default_nettype wire
